/* hw/cdma_engine.sv */
// Design decision made here: register access over APB.
module cdma_engine
  import cdma_pkg::*;
(
  input wire logic I_REF_CLK, // 25 MHz clock
  input wire logic I_RSTN, // async reset, active low
  input wire logic I_CE, // clock enable
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb enable
  input wire logic I_PWRITE, // apb direction
  input wire logic [7:0] I_PADDR, // apb byte address
  input wire logic [31:0] I_PWDATA, // apb write data
  output logic O_PREADY, // apb ready
  output logic [31:0] O_PRDATA, // apb read data
  output logic O_PSLVERR, // apb error, unmapped address
  output logic O_MEM_REQ, // master request, held to ack or master reset
  output cdma_mreq_type O_MEM, // master address and data
  input wire logic I_MEM_ACK, // master transfer done
  input wire logic I_MEM_ERR, // bus fault with ack
  input wire logic [31:0] I_MEM_RDATA, // master read data
  input wire logic [1:0] I_RX_VALID, // rx word offered per port
  input wire cdma_word_type [1:0] I_RX_WORD, // rx word per port
  output logic [1:0] O_RX_TAKE, // rx word consumed pulse
  output logic [1:0] O_TX_VALID, // tx word valid per port
  output cdma_word_type [1:0] O_TX_WORD, // tx word per port
  input wire logic [1:0] I_TX_READY, // tx sink ready
  output logic [3:0] O_DESC_IRQ, // descriptor event pulses
  output logic [3:0] O_STOP_IRQ // stopped event pulses
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] base_r [4];
  logic [31:0] cur_r [4];
  logic [CNT_W-1:0] frm_r [4];
  logic [3:0] run_r;
  logic dead_r;
  cdma_state_type state_r;
  logic [1:0] ch_r;
  logic [1:0] rr_r;
  logic [1:0] idx_r;
  logic [31:0] ctl_r;
  logic [31:0] len_r;
  logic [31:0] rem_r;
  logic [31:0] waddr_r;
  logic [31:0] nxt_r;
  logic got_last_r;
  logic mem_req_r;
  cdma_mreq_type mem_r;
  logic [1:0] rx_take_r;
  logic [1:0] txv_r;
  cdma_word_type [1:0] txw_r;
  logic [3:0] desc_irq_r;
  logic [3:0] stop_irq_r;

  // reset release through two flops
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // apb address decode
  wire apb_acc = I_PSEL & I_PENABLE & pready_r;
  wire hit_cmd_a = (I_PADDR == OFS_CMD_A);
  wire hit_cmd_b = (I_PADDR == OFS_CMD_B);
  wire aligned = (I_PADDR[1:0] == 2'h0);
  wire hit_base = aligned && I_PADDR >= OFS_BASE0 && I_PADDR <= OFS_BASE3;
  wire hit_cur = aligned && I_PADDR >= OFS_CUR0 && I_PADDR <= OFS_CUR3;
  wire hit_stat = (I_PADDR == OFS_STAT);
  wire [7:0] base_off = I_PADDR - OFS_BASE0;
  wire [7:0] cur_off = I_PADDR - OFS_CUR0;
  wire [1:0] base_idx = base_off[3:2];
  wire [1:0] cur_idx = cur_off[3:2];
  wire hit_any = hit_cmd_a | hit_cmd_b | hit_base | hit_cur | hit_stat;
  wire [31:0] stat_w = {27'h0, dead_r, run_r ^ 4'hF};
  // command registers read zero, commands are self-clearing
  wire [31:0] rdata_w = hit_base ? base_r[base_idx] :
                        hit_cur ? cur_r[cur_idx] :
                        hit_stat ? stat_w : 32'h0000_0000;

  // command pulses per channel: 0 A rx, 1 A tx, 2 B rx, 3 B tx
  wire wr_now = apb_acc & I_PWRITE;
  wire [31:0] wa = (wr_now & hit_cmd_a) ? I_PWDATA : 32'h0000_0000;
  wire [31:0] wb = (wr_now & hit_cmd_b) ? I_PWDATA : 32'h0000_0000;
  wire [3:0] cmd_go = {wb[CMD_GO_T], wb[CMD_GO_R],
                       wa[CMD_GO_T], wa[CMD_GO_R]};
  wire [3:0] cmd_stop = {wb[CMD_STOP_T], wb[CMD_STOP_R],
                         wa[CMD_STOP_T], wa[CMD_STOP_R]};
  wire [3:0] cmd_rst = {wb[CMD_RST_T], wb[CMD_RST_R],
                        wa[CMD_RST_T], wa[CMD_RST_R]};
  wire cmd_mrst = wa[CMD_MRST];

  // apb slave: answer in the cycle after setup
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (I_CE) begin
      pready_r <= I_PSEL & ~I_PENABLE;
      prdata_r <= rdata_w;
      pslverr_r <= I_PSEL & ~I_PENABLE & ~hit_any;
    end
  end

  // descriptor base registers
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        base_r[i] <= 32'h0000_0000;
      end
    end else if (I_CE && wr_now && hit_base) begin
      base_r[base_idx] <= I_PWDATA;
    end
  end

  // channel decode for the engine
  wire is_tx = ch_r[0];
  wire port = ch_r[1];
  wire rr_ok = run_r[rr_r] && (rr_r[0] || I_RX_VALID[rr_r[1]]);
  wire cstop_in = I_MEM_RDATA[CTL_CSTOP];
  wire [31:0] rx_nb32 = I_RX_WORD[port].last ?
                        {29'h0, I_RX_WORD[port].nbytes} : {29'h0, WORD_BYTES};
  wire [31:0] rx_nb = (rem_r < rx_nb32) ? rem_r : rx_nb32;
  wire [31:0] tx_nb = (rem_r < {29'h0, WORD_BYTES}) ? rem_r :
                      {29'h0, WORD_BYTES};
  wire [CNT_W-1:0] tx_nb_c = CNT_W'(tx_nb);
  wire tx_last = (frm_r[ch_r] != '0) && (frm_r[ch_r] <= tx_nb_c);
  // control word written back at the end of a descriptor
  wire [CNT_W-1:0] rx_cnt = got_last_r ? frm_r[ch_r] : CNT_W'(len_r);
  wire [31:0] wb_ctl = is_tx ?
    {ctl_r[CTL_FEND], 1'b1, ctl_r[CTL_IRQ:0]} :
    {got_last_r, 1'b1, ctl_r[CTL_IRQ], rx_cnt};
  wire mem_done = mem_req_r & I_MEM_ACK;
  wire [31:0] cur_ch = cur_r[ch_r];

  // descriptor engine shared by the four channels
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      run_r <= 4'h0;
      dead_r <= 1'b0;
      ch_r <= 2'h0;
      rr_r <= 2'h0;
      idx_r <= 2'h0;
      ctl_r <= 32'h0000_0000;
      len_r <= 32'h0000_0000;
      rem_r <= 32'h0000_0000;
      waddr_r <= 32'h0000_0000;
      nxt_r <= 32'h0000_0000;
      got_last_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_r <= '0;
      rx_take_r <= 2'h0;
      txv_r <= 2'h0;
      txw_r <= '0;
      desc_irq_r <= 4'h0;
      stop_irq_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cur_r[i] <= 32'h0000_0000;
        frm_r[i] <= '0;
      end
    end else if (I_CE) begin
      desc_irq_r <= 4'h0;
      stop_irq_r <= 4'h0;
      rx_take_r <= 2'h0;
      for (int p = 0; p < 2; p++) begin
        if (txv_r[p] && I_TX_READY[p]) begin
          txv_r[p] <= 1'b0;
        end
      end
      case (state_r)
        ST_IDLE: begin
          if (rr_ok) begin
            ch_r <= rr_r;
            idx_r <= DESC_CTL;
            mem_req_r <= 1'b1;
            mem_r <= '{we: 1'b0, addr: cur_r[rr_r], wdata: 32'h0};
            state_r <= ST_FETCH;
          end
          rr_r <= rr_r + 2'h1;
        end
        ST_FETCH: begin
          if (mem_done) begin
            mem_req_r <= 1'b0;
            case (idx_r)
              DESC_CTL: ctl_r <= I_MEM_RDATA;
              DESC_BUF: waddr_r <= I_MEM_RDATA;
              DESC_LEN: begin
                len_r <= I_MEM_RDATA;
                rem_r <= I_MEM_RDATA;
              end
              default: nxt_r <= I_MEM_RDATA;
            endcase
            if (idx_r == DESC_CTL && !is_tx && cstop_in) begin
              run_r[ch_r] <= 1'b0;
              stop_irq_r[ch_r] <= 1'b1;
              state_r <= ST_IDLE;
            end else if (idx_r == DESC_NXT) begin
              got_last_r <= 1'b0;
              if (is_tx && ctl_r[CTL_FEND]) begin
                frm_r[ch_r] <= ctl_r[CNT_W-1:0];
              end
              state_r <= ST_DATA;
            end else begin
              idx_r <= idx_r + 2'h1;
              mem_req_r <= 1'b1;
              mem_r.addr <= mem_r.addr + DESC_STEP;
            end
          end
        end
        ST_DATA: begin
          if (mem_done) begin
            mem_req_r <= 1'b0;
            waddr_r <= waddr_r + DESC_STEP;
            if (is_tx) begin
              txv_r[port] <= 1'b1;
              txw_r[port] <= '{data: I_MEM_RDATA, last: tx_last,
                               nbytes: tx_nb[2:0]};
              rem_r <= rem_r - tx_nb;
              frm_r[ch_r] <= tx_last ? '0 : frm_r[ch_r] - tx_nb_c;
            end
          end else if (mem_req_r || txv_r[port]) begin
            state_r <= ST_DATA;
          end else if (!run_r[ch_r]) begin
            state_r <= ST_IDLE;
          end else if (rem_r == 32'h0 || got_last_r) begin
            mem_req_r <= 1'b1;
            mem_r <= '{we: 1'b1, addr: cur_ch, wdata: wb_ctl};
            state_r <= ST_WBACK;
          end else if (is_tx) begin
            mem_req_r <= 1'b1;
            mem_r <= '{we: 1'b0, addr: waddr_r, wdata: 32'h0};
          end else if (I_RX_VALID[port]) begin
            mem_req_r <= 1'b1;
            mem_r <= '{we: 1'b1, addr: waddr_r,
                       wdata: I_RX_WORD[port].data};
            rx_take_r[port] <= 1'b1;
            rem_r <= rem_r - rx_nb;
            frm_r[ch_r] <= frm_r[ch_r] + CNT_W'(rx_nb);
            got_last_r <= I_RX_WORD[port].last;
          end
        end
        ST_WBACK: begin
          if (mem_done) begin
            mem_req_r <= 1'b0;
            desc_irq_r[ch_r] <= ctl_r[CTL_IRQ];
            if (!is_tx && got_last_r) begin
              frm_r[ch_r] <= '0;
            end
            if (is_tx && ctl_r[CTL_CSTOP]) begin
              run_r[ch_r] <= 1'b0;
              stop_irq_r[ch_r] <= 1'b1;
            end else begin
              cur_r[ch_r] <= nxt_r;
            end
            state_r <= ST_IDLE;
          end
        end
        ST_DEAD: state_r <= ST_DEAD;
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // software commands win over the engine's own updates
      for (int c = 0; c < 4; c++) begin
        if (cmd_go[c] && !run_r[c] && !dead_r) begin
          run_r[c] <= 1'b1;
          cur_r[c] <= base_r[c];
          frm_r[c] <= '0;
        end
        if (cmd_stop[c] && run_r[c]) begin
          run_r[c] <= 1'b0;
          stop_irq_r[c] <= 1'b1;
        end
        if (cmd_rst[c]) begin
          run_r[c] <= 1'b0;
          frm_r[c] <= '0;
        end
      end
      if (cmd_mrst) begin
        dead_r <= 1'b0;
        run_r <= 4'h0;
        mem_req_r <= 1'b0;
        txv_r <= 2'h0;
        state_r <= ST_IDLE;
      end
      // bus fault halts the master and all sections, beats a master reset
      if (mem_done && I_MEM_ERR) begin
        dead_r <= 1'b1;
        run_r <= 4'h0;
        mem_req_r <= 1'b0;
        state_r <= ST_DEAD;
      end
    end
  end

  // outputs straight from flops
  assign O_PREADY = pready_r;
  assign O_PRDATA = prdata_r;
  assign O_PSLVERR = pslverr_r;
  assign O_MEM_REQ = mem_req_r;
  assign O_MEM = mem_r;
  assign O_RX_TAKE = rx_take_r;
  assign O_TX_VALID = txv_r;
  assign O_TX_WORD = txw_r;
  assign O_DESC_IRQ = desc_irq_r;
  assign O_STOP_IRQ = stop_irq_r;
endmodule : cdma_engine

/* hw/cdma_pkg.sv */
package cdma_pkg;
  // register offsets on the apb side
  localparam logic [7:0] OFS_CMD_A = 8'h04;
  localparam logic [7:0] OFS_CMD_B = 8'h08;
  localparam logic [7:0] OFS_BASE0 = 8'h0C;
  localparam logic [7:0] OFS_BASE3 = 8'h18;
  localparam logic [7:0] OFS_CUR0 = 8'h20;
  localparam logic [7:0] OFS_CUR3 = 8'h2C;
  localparam logic [7:0] OFS_STAT = 8'h30;
  // command bit positions
  localparam int CMD_GO_R = 0;
  localparam int CMD_GO_T = 1;
  localparam int CMD_RST_R = 4;
  localparam int CMD_RST_T = 5;
  localparam int CMD_STOP_R = 8;
  localparam int CMD_STOP_T = 9;
  localparam int CMD_MRST = 16;
  // descriptor layout
  localparam logic [31:0] DESC_STEP = 32'h0000_0004;
  localparam logic [1:0] DESC_CTL = 2'h0;
  localparam logic [1:0] DESC_BUF = 2'h1;
  localparam logic [1:0] DESC_LEN = 2'h2;
  localparam logic [1:0] DESC_NXT = 2'h3;
  localparam int CTL_FEND = 31;
  localparam int CTL_CSTOP = 30;
  localparam int CTL_IRQ = 29;
  localparam int CNT_W = 29;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  // engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_DATA = 5'h04,
    ST_WBACK = 5'h08,
    ST_DEAD = 5'h10
  } cdma_state_type;
  // one stream word with its byte count and frame end
  typedef struct packed {
    logic [31:0] data;
    logic last;
    logic [2:0] nbytes;
  } cdma_word_type;
  // one memory request of the bus master
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cdma_mreq_type;
endpackage : cdma_pkg

/* test/cdma_engine_checker.sv */
module cdma_engine_checker
  import cdma_pkg::*;
(
  input wire logic I_REF_CLK, // clock
  input wire logic I_RSTN, // reset, active low
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb enable
  input wire logic I_PWRITE, // apb direction
  input wire logic [7:0] I_PADDR, // apb address
  input wire logic O_PREADY, // apb ready
  input wire logic [31:0] O_PRDATA, // apb read data
  input wire logic O_MEM_REQ, // master request
  input wire cdma_mreq_type O_MEM, // master request body
  input wire logic I_MEM_ACK, // master done
  input wire logic I_MEM_ERR, // master fault
  input wire logic [1:0] O_TX_VALID, // tx valid
  input wire cdma_word_type [1:0] O_TX_WORD, // tx word
  input wire logic [1:0] I_TX_READY, // tx ready
  input wire logic [3:0] O_DESC_IRQ, // descriptor events
  input wire logic [3:0] O_STOP_IRQ // stopped events
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  // read access completing in this cycle
  wire rd_done = I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE;
  // register reads
  property p_stat_hi;
    rd_done && I_PADDR == OFS_STAT |-> O_PRDATA[31:5] == 27'h0;
  endproperty
  a_stat_hi: assert property (p_stat_hi)
    else $error("status high bits");
  property p_cmd_zero;
    rd_done && (I_PADDR == OFS_CMD_A || I_PADDR == OFS_CMD_B)
      |-> O_PRDATA == 32'h0;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("command not zero");
  // memory master
  property p_dead;
    O_MEM_REQ && I_MEM_ACK && I_MEM_ERR |=> !O_MEM_REQ [*8];
  endproperty
  a_dead: assert property (p_dead)
    else $error("request after fault");
  property p_hold;
    O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request not held");
  property p_align;
    O_MEM_REQ |-> O_MEM.addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("address not aligned");
  // stream and events
  property p_tx_hold;
    O_TX_VALID[0] && !I_TX_READY[0] |=> O_TX_VALID[0] && $stable(O_TX_WORD);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx word dropped");
  property p_desc_pulse;
    O_DESC_IRQ != 4'h0 |=> O_DESC_IRQ == 4'h0;
  endproperty
  a_desc_pulse: assert property (p_desc_pulse)
    else $error("desc event");
  property p_stop_pulse;
    O_STOP_IRQ != 4'h0 |=> O_STOP_IRQ == 4'h0;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop event");
endmodule : cdma_engine_checker

bind cdma_engine cdma_engine_checker i_cdma_engine_checker (.I_REF_CLK,
  .I_RSTN, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PREADY, .O_PRDATA,
  .O_MEM_REQ, .O_MEM, .I_MEM_ACK, .I_MEM_ERR, .O_TX_VALID, .O_TX_WORD,
  .I_TX_READY, .O_DESC_IRQ, .O_STOP_IRQ);

/* test/cdma_host_mem.sv */
module cdma_host_mem
  import cdma_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_req, // engine request
  input wire cdma_mreq_type i_mreq, // address and data
  input wire logic i_fault, // answer with a bus fault
  output logic o_ack = 1'b0, // done pulse
  output logic o_err = 1'b0, // fault with done
  output logic [31:0] o_rdata = 32'h0 // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [31:0]];
  int wait_r = 0;
  // answer each request after 0 to 3 idle cycles
  always @(posedge i_clk) begin
    if (o_ack || !i_req) begin
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= ~o_rdata; // data not held after the answer
      wait_r <= $urandom % 4;
    end else if (wait_r > 0) begin
      wait_r <= wait_r - 1;
    end else begin
      o_ack <= 1'b1;
      o_err <= i_fault;
      if (i_mreq.we) mem[i_mreq.addr] = i_mreq.wdata;
      else o_rdata <= mem[i_mreq.addr];
    end
  end
endmodule : cdma_host_mem

/* test/tb.sv */
module tb
  import cdma_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic fault = 1'b0, pready, perr, mreq, ack, err, rerr;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rdv, mrd;
  logic [1:0] rxv = 2'h0, take, txv, rdy_rnd = 2'h0, rdy_msk = 2'h3;
  logic [3:0] dirq, sirq;
  cdma_word_type [1:0] rxw = '0, txw;
  cdma_word_type w0, w1, txq [$];
  cdma_mreq_type mem_o;
  logic [31:0] exp_d [$];
  int miscompares = 0, checked = 0, cyc = 0, left, nb;
  int dcnt [4] = '{default: 0}, scnt [4] = '{default: 0};
  // 25 MHz clock
  always #20 clk = ~clk;
  cdma_engine i_cdma_engine (.I_REF_CLK(clk), .I_RSTN(rst_n), .I_CE(1'b1),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
    .I_PWDATA(pwd), .O_PREADY(pready), .O_PRDATA(prd), .O_PSLVERR(perr),
    .O_MEM_REQ(mreq), .O_MEM(mem_o), .I_MEM_ACK(ack), .I_MEM_ERR(err),
    .I_MEM_RDATA(mrd), .I_RX_VALID(rxv), .I_RX_WORD(rxw), .O_RX_TAKE(take),
    .O_TX_VALID(txv), .O_TX_WORD(txw), .I_TX_READY(rdy_rnd & rdy_msk),
    .O_DESC_IRQ(dirq), .O_STOP_IRQ(sirq));
  cdma_host_mem i_cdma_host_mem (.i_clk(clk), .i_req(mreq), .i_mreq(mem_o),
    .i_fault(fault), .o_ack(ack), .o_err(err), .o_rdata(mrd));
  // random tx ready, event counts, port A tx words, hang limit
  always @(posedge clk) begin
    cyc++;
    rdy_rnd <= 2'($urandom);
    for (int k = 0; k < 4; k++) begin
      dcnt[k] += int'(dirq[k] === 1'b1);
      scnt[k] += int'(sirq[k] === 1'b1);
    end
    if (txv[0] && rdy_rnd[0] && rdy_msk[0]) txq.push_back(txw[0]);
    if (cyc == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_cnt
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_stat(input int b);
    do apb(1'b0, OFS_STAT, 32'h0);
    while (rdv[b] !== 1'b1);
  endtask : wait_stat
  function automatic logic [31:0] peek(input logic [31:0] a);
    return i_cdma_host_mem.mem[a];
  endfunction : peek
  task automatic put_desc(input logic [31:0] a, c, b, l, n);
    i_cdma_host_mem.mem[a] = c;
    i_cdma_host_mem.mem[a + 32'h4] = b;
    i_cdma_host_mem.mem[a + 32'h8] = l;
    i_cdma_host_mem.mem[a + 32'hC] = n;
  endtask : put_desc
  task automatic rx_send(input int p, input cdma_word_type w);
    rxw[p] <= w;
    rxv[p] <= 1'b1;
    @(posedge clk);
    while (take[p] !== 1'b1) @(posedge clk);
  endtask : rx_send
  // main sequence
  initial begin
    void'($urandom(31896));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp_word(rdv, 32'h0000_000F);
    apb(1'b1, OFS_STAT, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp_word(rdv, 32'h0000_000F);
    apb(1'b0, 8'h00, 32'h0);
    cmp_word({31'h0, rerr}, 32'h1);
    // two-descriptor frame on port A tx, frame end count 6
    exp_d = '{$urandom, $urandom};
    put_desc(32'h100, 32'hA000_0006, 32'h200, 32'h4, 32'h110);
    put_desc(32'h110, 32'h4000_0000, 32'h300, 32'h2, 32'h120);
    i_cdma_host_mem.mem[32'h200] = exp_d[0];
    i_cdma_host_mem.mem[32'h300] = exp_d[1];
    apb(1'b1, OFS_BASE0 + 8'h04, 32'h100);
    apb(1'b1, OFS_CMD_A, 32'h2);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp_word(rdv, 32'h0000_000D);
    wait_stat(1);
    cmp_cnt(txq.size(), 2);
    left = 6;
    foreach (txq[i]) begin
      nb = (left > 4) ? 4 : left;
      cmp_word(txq[i].data, exp_d[i]);
      cmp_word({31'h0, txq[i].last}, {31'h0, left <= 4});
      if (left <= 4) cmp_word({29'h0, txq[i].nbytes}, 32'(nb));
      left -= nb;
    end
    apb(1'b0, OFS_STAT, 32'h0);
    cmp_word(rdv, 32'h0000_000F);
    cmp_word(peek(32'h100), 32'hE000_0006);
    cmp_word(peek(32'h110), 32'h4000_0000);
    cmp_cnt(dcnt[1], 1);
    cmp_cnt(scnt[1], 1);
    // port B receive frame of 7 bytes, then a stop descriptor
    w0 = '{data: $urandom, last: 1'b0, nbytes: 3'h4};
    w1 = '{data: $urandom, last: 1'b1, nbytes: 3'h3};
    put_desc(32'h400, 32'h2000_0000, 32'h500, 32'h8, 32'h410);
    put_desc(32'h410, 32'h4000_0000, 32'h600, 32'h8, 32'h420);
    apb(1'b1, OFS_BASE0 + 8'h08, 32'h400);
    apb(1'b1, OFS_CMD_B, 32'h1);
    rx_send(1, w0);
    rx_send(1, w1);
    // a word stays offered: the stop descriptor is fetched only then
    wait_stat(2);
    rxv[1] <= 1'b0;
    apb(1'b0, OFS_CUR0 + 8'h08, 32'h0);
    cmp_word(rdv, 32'h410);
    cmp_word(peek(32'h400), 32'hE000_0007);
    cmp_word(peek(32'h410), 32'h4000_0000);
    cmp_word(peek(32'h500), w0.data);
    cmp_word(peek(32'h504), w1.data);
    cmp_cnt(dcnt[2], 1);
    cmp_cnt(scnt[2], 1);
    // port A receive frame of 6 bytes over two descriptors, then a stop
    w1.nbytes = 3'h2;
    put_desc(32'hA00, 32'h0, 32'hB00, 32'h4, 32'hA10);
    put_desc(32'hA10, 32'h0, 32'hC00, 32'h8, 32'hA20);
    put_desc(32'hA20, 32'h4000_0000, 32'hD00, 32'h8, 32'hA30);
    apb(1'b1, OFS_BASE0, 32'hA00);
    apb(1'b1, OFS_CMD_A, 32'h1);
    rx_send(0, w0);
    rx_send(0, w1);
    wait_stat(0);
    rxv[0] <= 1'b0;
    cmp_word(peek(32'hA00), 32'h4000_0004);
    cmp_word(peek(32'hA10), 32'hC000_0006);
    cmp_word(peek(32'hB00), w0.data);
    cmp_word(peek(32'hC00), w1.data);
    cmp_word(peek(32'hA20), 32'h4000_0000);
    cmp_cnt(dcnt[0], 0);
    cmp_cnt(scnt[0], 1);
    // forced stop of port B tx while its sink stalls
    rdy_msk <= 2'h1;
    put_desc(32'h700, 32'h8000_0004, 32'h800, 32'h4, 32'h710);
    put_desc(32'h710, 32'h4000_0000, 32'h800, 32'h4, 32'h720);
    i_cdma_host_mem.mem[32'h800] = $urandom;
    apb(1'b1, OFS_BASE3, 32'h700);
    apb(1'b1, OFS_CMD_B, 32'h2);
    while (txv[1] !== 1'b1) @(posedge clk);
    apb(1'b1, OFS_CMD_B, 32'h200);
    apb(1'b0, OFS_CMD_B, 32'h0);
    cmp_word(rdv, 32'h0);
    rdy_msk <= 2'h3;
    wait_stat(3);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp_cnt(scnt[3], 1);
    // bus fault, port B master reset refused, port A master reset
    fault <= 1'b1;
    put_desc(32'h900, 32'h4000_0000, 32'h800, 32'h4, 32'h910);
    apb(1'b1, OFS_BASE0 + 8'h04, 32'h900);
    apb(1'b1, OFS_CMD_A, 32'h2);
    wait_stat(4);
    fault <= 1'b0;
    cmp_word(rdv, 32'h0000_001F);
    apb(1'b1, OFS_CMD_B, 32'h0001_0000);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp_word(rdv, 32'h0000_001F);
    apb(1'b1, OFS_CMD_A, 32'h0001_0000);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp_word(rdv, 32'h0000_000F);
    give_verdict();
  end
endmodule : tb
